// ---- core/tba_timer16.v ----
/*
  Byte-access front end of a reduced 16-bit timer with input capture.
  Assumes a processor on an 8-bit bus, one access per enabled cycle, and
  synchronous inputs; prescaled internal ticks arrive on INT_TICK.
*/
// Function
// RULE1 - 16-bit counter and capture, byte accessed
// RULE2 - One shared high-byte holding register
// RULE3 - Low-byte write loads full 16 bits; the capture low write loads only while TOP_SEL selects capture as top
// RULE4 - Low-byte read copies high into holding
// RULE5 - Write high first, read low first
// RULE6 - Software blocks interrupts across byte pair
// RULE7 - Control registers accessed directly, single byte
// RULE8 - Flags gated to processor by masks
// RULE9 - Clock select makes tick, idle if none
// RULE10 - Capture counter on edge, optional filter; no capture is taken while TOP_SEL selects capture as top
// RULE11 - Bottom at 0x0000, max at 0xFFFF
// RULE12 - Top is fixed value or capture
// RULE13 - Holding reuse allowed for same high byte
// RULE14 - Processor write beats counter clear/increment
// RULE15 - Capture flag set with capture copy
// RULE16 - Holding resets zero, limited update sources
`timescale 1ns/100ps
`default_nettype none
`include "tba_consts.vh"

module tba_timer16 (
  // Clock, reset, enable.
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  // Processor byte bus.
  input wire [2:0] ADDR,
  input wire WR_EN,
  input wire RD_EN,
  input wire [7:0] WR_DATA,
  output reg [7:0] RD_DATA,
  // Timing configuration.
  input wire [2:0] CLK_SEL,
  input wire INT_TICK,
  input wire [2:0] TOP_SEL,
  input wire FILTER_EN,
  input wire CAPTURE_RISE,
  // Pins.
  input wire EXT_COUNT_PIN,
  input wire CAPTURE_PIN,
  // Status.
  output wire TIMER_TICK,
  output wire AT_BOTTOM,
  output wire AT_MAX,
  output wire AT_TOP,
  output wire [1:0] IRQ
);

  reg [15:0] timer_count_value; // Live counter.
  reg [15:0] capture_value_reg; // Captured or top value.
  reg [7:0] hold_hi; // Shared high-byte holding register.
  reg [7:0] timer_ctrl_a; // Plain control byte A.
  reg [7:0] timer_ctrl_b; // Plain control byte B.
  reg [1:0] timer_flag_reg; // Sticky flags.
  reg [1:0] timer_mask_reg; // Interrupt masks.
  reg ext_prev; // Last sample of the count pin.
  reg [3:0] filt_shift; // Capture pin sample history.
  reg cap_level; // Filtered capture level.
  reg cap_prev; // Previous capture level for edge detect.
  reg [15:0] top_value; // Selected top.
  // Decoded write strobes and pin events.
  wire cnt_lo_wr;
  wire cap_lo_wr;
  wire cap_in;
  wire cap_event;
  wire ovf_event;
  wire ext_edge;

  // Low-byte writes are the only strobes that load a full 16-bit register.
  assign cnt_lo_wr = WR_EN && (ADDR == `TBA_ADDR_CNT_LO);
  assign cap_lo_wr = WR_EN && (ADDR == `TBA_ADDR_CAP_LO);

  // Top selection; unknown codes fall back to max.
  always @* begin
    case (TOP_SEL)
      `TBA_TOPSEL_8BIT: top_value = `TBA_TOP_8BIT; // see RULE12
      `TBA_TOPSEL_9BIT: top_value = `TBA_TOP_9BIT;
      `TBA_TOPSEL_10BIT: top_value = `TBA_TOP_10BIT;
      `TBA_TOPSEL_CAP: top_value = capture_value_reg;
      default: top_value = `TBA_MAX;
    endcase
  end

  assign AT_BOTTOM = (timer_count_value == `TBA_BOTTOM); // see RULE11
  assign AT_MAX = (timer_count_value == `TBA_MAX); // see RULE11
  assign AT_TOP = (timer_count_value == top_value); // see RULE12

  // External edges come from the registered previous sample, so the pin is
  // assumed already synchronous; a pulse shorter than a cycle may be lost.
  assign ext_edge = (CLK_SEL == `TBA_CS_EXT_RISE) ? (EXT_COUNT_PIN && !ext_prev) :
                    (!EXT_COUNT_PIN && ext_prev);
  // Idle when no source chosen; codes 1..5 take the internal tick.
  assign TIMER_TICK = CE && ((CLK_SEL == `TBA_CS_NONE) ? 1'b0 :
                      (CLK_SEL >= `TBA_CS_EXT_FALL) ? ext_edge : INT_TICK); // see RULE9

  // Filter adds latency of its length plus one cycle but rejects spikes.
  assign cap_in = FILTER_EN ? cap_level : CAPTURE_PIN; // see RULE10
  assign cap_event = CE && (CAPTURE_RISE ? (cap_in && !cap_prev) : (!cap_in && cap_prev));
  // A counter write in the same cycle replaces the wrap, so no overflow is flagged.
  assign ovf_event = TIMER_TICK && AT_TOP && !cnt_lo_wr;

  assign IRQ = timer_flag_reg & timer_mask_reg; // see RULE8

  // Pin sampling and filter history.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      // Edge history starts at the pins' present levels, so a pin that idles
      // high gives no false count or capture edge on the first cycle after reset.
      ext_prev <= EXT_COUNT_PIN;
      filt_shift <= {`TBA_FILT_LEN{CAPTURE_PIN}};
      cap_level <= CAPTURE_PIN;
      cap_prev <= CAPTURE_PIN;
    end else if (CE) begin
      ext_prev <= EXT_COUNT_PIN;
      filt_shift <= {filt_shift[`TBA_FILT_LEN-2:0], CAPTURE_PIN};
      // Level changes only after a run of equal samples.
      if (filt_shift == `TBA_FILT_ONES) begin
        cap_level <= 1'b1; // see RULE10
      end else if (filt_shift == `TBA_FILT_ZEROS) begin
        cap_level <= 1'b0;
      end
      cap_prev <= cap_in;
    end
  end

  // Counter: processor low-byte write wins over counting.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      timer_count_value <= `TBA_ZERO16;
    end else if (CE) begin
      if (cnt_lo_wr) begin
        timer_count_value <= {hold_hi, WR_DATA}; // see RULE3, see RULE14
      end else if (TIMER_TICK) begin
        if (AT_TOP) begin
          timer_count_value <= `TBA_ZERO16; // see RULE12
        end else begin
          timer_count_value <= timer_count_value + 16'h0001;
        end
      end
    end
  end

  // Capture register: software write allowed only in capture-top mode.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      capture_value_reg <= `TBA_ZERO16;
    end else if (CE) begin
      if (cap_lo_wr && (TOP_SEL == `TBA_TOPSEL_CAP)) begin
        capture_value_reg <= {hold_hi, WR_DATA}; // see RULE3
      end else if (cap_event && (TOP_SEL != `TBA_TOPSEL_CAP)) begin
        capture_value_reg <= timer_count_value; // see RULE10
      end
    end
  end

  // Holding register: high writes and low reads only.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      hold_hi <= `TBA_ZERO8; // see RULE16
    end else if (CE) begin
      if (WR_EN && ((ADDR == `TBA_ADDR_CNT_HI) || (ADDR == `TBA_ADDR_CAP_HI))) begin
        hold_hi <= WR_DATA; // see RULE2, see RULE16
      end else if (RD_EN && (ADDR == `TBA_ADDR_CNT_LO)) begin
        hold_hi <= timer_count_value[15:8]; // see RULE4
      end else if (RD_EN && (ADDR == `TBA_ADDR_CAP_LO)) begin
        hold_hi <= capture_value_reg[15:8]; // see RULE4
      end
    end
  end

  // Direct byte registers and sticky flags; set beats write-one clear.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      timer_ctrl_a <= `TBA_ZERO8;
      timer_ctrl_b <= `TBA_ZERO8;
      timer_flag_reg <= `TBA_ZERO2;
      timer_mask_reg <= `TBA_ZERO2;
    end else if (CE) begin
      if (WR_EN && (ADDR == `TBA_ADDR_CTRL_A)) begin
        timer_ctrl_a <= WR_DATA; // see RULE7
      end
      if (WR_EN && (ADDR == `TBA_ADDR_CTRL_B)) begin
        timer_ctrl_b <= WR_DATA; // see RULE7
      end
      if (WR_EN && (ADDR == `TBA_ADDR_MASK)) begin
        timer_mask_reg <= WR_DATA[1:0];
      end
      timer_flag_reg[`TBA_FLAG_OVF] <= ovf_event ||
        (timer_flag_reg[`TBA_FLAG_OVF] &&
         !(WR_EN && (ADDR == `TBA_ADDR_FLAG) && WR_DATA[`TBA_FLAG_OVF]));
      timer_flag_reg[`TBA_FLAG_CAP] <= (cap_event && (TOP_SEL != `TBA_TOPSEL_CAP)) ||
        (timer_flag_reg[`TBA_FLAG_CAP] &&
         !(WR_EN && (ADDR == `TBA_ADDR_FLAG) && WR_DATA[`TBA_FLAG_CAP])); // see RULE15
    end
  end

  // Read data registered one cycle after RD_EN.
  always @(posedge CLK_SYS) begin
    if (RST) begin
      RD_DATA <= `TBA_ZERO8;
    end else if (CE && RD_EN) begin
      case (ADDR)
        `TBA_ADDR_CNT_LO: RD_DATA <= timer_count_value[7:0]; // see RULE1
        `TBA_ADDR_CAP_LO: RD_DATA <= capture_value_reg[7:0];
        `TBA_ADDR_CNT_HI: RD_DATA <= hold_hi; // see RULE4
        `TBA_ADDR_CAP_HI: RD_DATA <= hold_hi;
        `TBA_ADDR_CTRL_A: RD_DATA <= timer_ctrl_a;
        `TBA_ADDR_CTRL_B: RD_DATA <= timer_ctrl_b;
        `TBA_ADDR_FLAG: RD_DATA <= {6'h00, timer_flag_reg};
        `TBA_ADDR_MASK: RD_DATA <= {6'h00, timer_mask_reg};
        default: RD_DATA <= `TBA_ZERO8;
      endcase
    end
  end

endmodule // tba_timer16
`default_nettype wire

// ---- core/tba_consts.vh ----
/*
  Constants for the 16-bit timer byte-access front end.
  Assumes inclusion by bare name from design files under core/.
*/
`ifndef TBA_CONSTS_VH
`define TBA_CONSTS_VH

// Byte address selects on the 8-bit processor bus.
`define TBA_ADDR_CNT_LO 3'h0
`define TBA_ADDR_CNT_HI 3'h1
`define TBA_ADDR_CAP_LO 3'h2
`define TBA_ADDR_CAP_HI 3'h3
`define TBA_ADDR_CTRL_A 3'h4
`define TBA_ADDR_CTRL_B 3'h5
`define TBA_ADDR_FLAG 3'h6
`define TBA_ADDR_MASK 3'h7

// Reset values.
`define TBA_ZERO8 8'h00
`define TBA_ZERO16 16'h0000
`define TBA_ZERO2 2'h0

// Counter end values.
`define TBA_BOTTOM 16'h0000
`define TBA_MAX 16'hffff
`define TBA_TOP_8BIT 16'h00ff
`define TBA_TOP_9BIT 16'h01ff
`define TBA_TOP_10BIT 16'h03ff

// Top select codes.
`define TBA_TOPSEL_MAX 3'h0
`define TBA_TOPSEL_8BIT 3'h1
`define TBA_TOPSEL_9BIT 3'h2
`define TBA_TOPSEL_10BIT 3'h3
`define TBA_TOPSEL_CAP 3'h4

// Clock select codes.
`define TBA_CS_NONE 3'h0
`define TBA_CS_EXT_FALL 3'h6
`define TBA_CS_EXT_RISE 3'h7

// Flag bit positions: overflow and capture.
`define TBA_FLAG_OVF 0
`define TBA_FLAG_CAP 1

// Noise filter length in samples.
`define TBA_FILT_LEN 4
`define TBA_FILT_ONES 4'hf
`define TBA_FILT_ZEROS 4'h0

`endif

// ---- tb/tba_timer16_asserts.sv ----
/* Port checker for the timer byte-access block.
   Assumes CE is high whenever requests are made. */
`timescale 1ns/100ps
`default_nettype none
`include "tba_consts.vh"
module tba_timer16_asserts (
  // Clock, reset, enable.
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Processor bus.
  input wire logic [2:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_DATA,
  // Timing inputs.
  input wire logic [2:0] CLK_SEL,
  input wire logic INT_TICK,
  input wire logic EXT_COUNT_PIN,
  // Status outputs.
  input wire logic TIMER_TICK,
  input wire logic AT_BOTTOM,
  input wire logic AT_MAX,
  input wire logic [1:0] IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // A high-byte location is 1 or 3; both share one holding register.
  wire hi_a = ADDR[0] & ~ADDR[2];
  wire idle = ~WR_EN & ~RD_EN;
  idle_tick_a: assert property (CLK_SEL == `TBA_CS_NONE |-> !TIMER_TICK)
    else $error("tick with no source");
  int_tick_a: assert property (CE && CLK_SEL != 0 && CLK_SEL < 6 |-> TIMER_TICK == INT_TICK)
    else $error("internal tick not passed");
  ext_rise_a: assert property (CE && CLK_SEL == 7 && $rose(EXT_COUNT_PIN) |-> TIMER_TICK)
    else $error("external rise missed");
  ctrl_direct_a: assert property (CE && WR_EN && ADDR == 4 ##1 idle ##1 RD_EN && ADDR == 4
    |=> RD_DATA == $past(WR_DATA, 3)) else $error("control byte lost");
  hold_share_a: assert property (CE && WR_EN && hi_a ##1 idle ##1 RD_EN && hi_a
    |=> RD_DATA == $past(WR_DATA, 3)) else $error("holding not shared");
  load_full_a: assert property (WR_EN && ADDR == 1 && WR_DATA == 8'hff ##1 idle
    ##1 WR_EN && ADDR == 0 && WR_DATA == 8'hff |=> AT_MAX) else $error("word not loaded");
  mask_off_a: assert property (CE && WR_EN && ADDR == 7 && WR_DATA[1:0] == 0 |=> IRQ == 0)
    else $error("request not masked");
  reset_clear_a: assert property (disable iff (1'b0) RST && CE
    |=> AT_BOTTOM && RD_DATA == 8'h00 && IRQ == 2'h0) else $error("reset state wrong");
  cover property (RD_EN && ADDR == 2);
  cover property (TIMER_TICK && CLK_SEL == 7);
  cover property ($rose(IRQ[1]));
endmodule // tba_timer16_asserts
bind tba_timer16 tba_timer16_asserts tba_timer16_asserts_inst (.CLK_SYS(CLK_SYS), .RST(RST),
  .CE(CE), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .CLK_SEL(CLK_SEL), .INT_TICK(INT_TICK), .EXT_COUNT_PIN(EXT_COUNT_PIN),
  .TIMER_TICK(TIMER_TICK), .AT_BOTTOM(AT_BOTTOM), .AT_MAX(AT_MAX), .IRQ(IRQ));
`default_nettype wire

// ---- tb/tba_cpu_model.sv ----
/* Processor model on the 8-bit bus of the timer.
   Assumes requests are taken on the rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module tba_cpu_model (
  // Clock and answer.
  input wire logic clk,
  input wire logic [7:0] rd_data,
  // Requests.
  output var logic [2:0] addr = 3'h0,
  output var logic wr_en = 1'b0,
  output var logic rd_en = 1'b0,
  output var logic [7:0] wr_data = 8'h00
);
  // Byte write; the released data line shows the inverse so stale data never passes.
  task wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask
  // Byte read; the answer is taken once the answering edge has settled.
  task rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  // Word accesses run to the end uninterrupted, so the holding register is safe.
  task wr16(input logic [2:0] a, input logic [15:0] v);
    wr8(a | 3'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  task rd16(input logic [2:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a | 3'h1, v[15:8]);
  endtask
endmodule // tba_cpu_model
`default_nettype wire

// ---- tb/tba_timer16_test.sv ----
/* Self-checking bench for the timer byte-access block.
   Assumes the processor model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "tba_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tba_timer16_test;
  logic clk, rst, tick, cap, ext;
  logic filt, rise;
  logic [2:0] csel, tsel, a;
  logic [7:0] d;
  logic [15:0] v;
  wire [2:0] addr;
  wire wr, rd, t_tick, at_bot, at_max, at_top;
  wire [7:0] wdat, rdat;
  wire [1:0] irq;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Rows: location, word written, word read back.
  logic [34:0] rows [6] = '{{3'h0, 16'h01ff, 16'h01ff}, {3'h0, 16'hffff, 16'hffff},
    {3'h2, 16'h1234, 16'h1234}, {3'h4, 16'h00a5, 16'h00a5}, {3'h5, 16'h005a, 16'h005a},
    {3'h7, 16'h00fc, 16'h0000}};
  tba_cpu_model cpu (.clk(clk), .rd_data(rdat), .addr(addr), .wr_en(wr), .rd_en(rd),
    .wr_data(wdat));
  tba_timer16 tba_timer16_inst (.CLK_SYS(clk), .RST(rst), .CE(1'b1), .ADDR(addr),
    .WR_EN(wr), .RD_EN(rd), .WR_DATA(wdat), .RD_DATA(rdat), .CLK_SEL(csel),
    .INT_TICK(tick), .TOP_SEL(tsel), .FILTER_EN(filt), .CAPTURE_RISE(rise),
    .EXT_COUNT_PIN(ext), .CAPTURE_PIN(cap), .TIMER_TICK(t_tick), .AT_BOTTOM(at_bot),
    .AT_MAX(at_max), .AT_TOP(at_top), .IRQ(irq));
  // Prints the counts and the verdict, then stops.
  task results;
    $display("checks %0d wrong %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {rst, tick, cap, ext, csel, tsel} = {4'h8, 3'h0, `TBA_TOPSEL_CAP};
    {filt, rise} = 2'h1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cpu.rd8(3'h1, d);
    `CHK("holding", 8'h00, d)
    foreach (rows[i]) begin
      a = rows[i][34:32];
      if (a < 3'h4) begin
        cpu.wr16(a, rows[i][31:16]);
        cpu.rd16(a, v);
      end else begin
        cpu.wr8(a, rows[i][23:16]);
        cpu.rd8(a, d);
        v = {8'h00, d};
      end
      `CHK("row", rows[i][15:0], v)
    end
    cpu.wr8(3'h3, 8'h5c);
    cpu.rd8(3'h1, d);
    `CHK("shared", 8'h5c, d)
    cpu.wr16(3'h0, 16'hab12);
    cpu.wr16(3'h2, 16'h34cd);
    cpu.rd8(3'h2, d);
    cpu.rd8(3'h1, d);
    `CHK("copy", 8'h34, d)
    cpu.wr8(3'h1, 8'h77);
    cpu.wr8(3'h0, 8'h01);
    cpu.wr8(3'h2, 8'h02);
    cpu.rd16(3'h0, v);
    `CHK("reuse", 16'h7701, v)
    cpu.rd16(3'h2, v);
    `CHK("reuse", 16'h7702, v)
    // A write while ticking must win; the later read sees one more tick.
    cpu.wr8(3'h7, 8'h01);
    cpu.wr16(3'h0, 16'h0005);
    @(posedge clk) {csel, tsel, tick} <= {3'h1, `TBA_TOPSEL_8BIT, 1'b1};
    cpu.wr16(3'h0, 16'h00f0);
    cpu.rd8(3'h0, d);
    `CHK("priority", 8'hf1, d)
    repeat (20) @(posedge clk);
    #1;
    `CHK("overflow", 1'b1, irq[0])
    @(posedge clk) {csel, tsel, tick} <= {`TBA_CS_NONE, `TBA_TOPSEL_MAX, 1'b0};
    cpu.wr8(3'h7, 8'h02);
    cpu.wr16(3'h0, 16'h4321);
    @(posedge clk) cap <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq", 2'h2, irq)
    cpu.rd16(3'h2, v);
    `CHK("capture", 16'h4321, v)
    @(posedge clk) csel <= `TBA_CS_EXT_RISE;
    @(posedge clk) ext <= 1'b1;
    #1;
    `CHK("tick", 1'b1, t_tick)
    @(posedge clk) ext <= 1'b0;
    @(posedge clk) ext <= 1'b1;
    repeat (2) @(posedge clk);
    csel <= `TBA_CS_NONE;
    cpu.rd16(3'h0, v);
    `CHK("external", 16'h4323, v)
    // Flags stay readable while masked off, and a written one clears them.
    cpu.wr8(3'h7, 8'hfc);
    cpu.rd8(3'h6, d);
    `CHK("flags", 8'h03, d)
    `CHK("masked", 2'h0, irq)
    cpu.wr8(3'h6, 8'h03);
    cpu.rd8(3'h6, d);
    `CHK("cleared", 8'h00, d)
    // Filtered falling capture: a one-cycle spike is rejected, a long low is taken.
    @(posedge clk) {filt, rise} <= 2'h2;
    @(posedge clk) cap <= 1'b0;
    @(posedge clk) cap <= 1'b1;
    cpu.rd8(3'h6, d);
    `CHK("spike", 8'h00, d)
    @(posedge clk) cap <= 1'b0;
    repeat (8) @(posedge clk);
    cpu.rd8(3'h6, d);
    `CHK("filtered", 8'h02, d)
    cpu.rd16(3'h2, v);
    `CHK("fall capture", 16'h4323, v)
    // Mid-run reset must clear counter, holding byte and requests.
    cpu.wr8(3'h7, 8'h03);
    cpu.wr16(3'h0, 16'hffff);
    cpu.rd8(3'h0, d);
    `CHK("max lo", 8'hff, d)
    `CHK("max", 1'b1, at_max)
    `CHK("top", 1'b1, at_top)
    `CHK("not bottom", 1'b0, at_bot)
    `CHK("pending", 2'h2, irq)
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cpu.rd8(3'h1, d);
    `CHK("reset holding", 8'h00, d)
    `CHK("bottom", 1'b1, at_bot)
    `CHK("reset irq", 2'h0, irq)
    results();
  end
endmodule // tba_timer16_test
`default_nettype wire
